// ==== rtl/clock_multiplier_control.sv ====
// clock multiplier control register, lock sequencing and pin use
//
// Behaviour
// [R1] multiplier runs only while enable is set
// [R2] initialize reads zero while multiplier enabled
// [R3] writing initialize when enabled starts locking
// [R4] ready reads one only when locked
// [R5] scale field picks 1, 2/3 .. 2/7 ratio
// [R6] odd ratios may give uneven duty cycle
// [R7] source field picks internal/external, x2/x4
// [R8] internal x2 source ignores scale field
// [R9] crystal uses both pins, off mode none, others output pin
// [R10] software skips and sets oscillator pin modes
// [R11] software follows enable, wait, init, poll order
// [R12] external oscillator stable before initialization
// [R13] slow input gives two-pulse (x2) or four-pulse (x4) bursts per edge
// [R14] ready clears on disable or re-initialization
`timescale 1ns/100ps
`include "pll_defs.svh"
module clock_multiplier_control import pll_pkg::*; (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // special function register port
  input wire sfr_req_t i_sfr_req,
  output logic [7:0] o_sfr_rdata,
  // oscillator inputs, asynchronous to i_sys_clk
  input wire logic i_int_osc_clk,
  input wire logic i_ext_osc_clk,
  input wire logic [2:0] i_osc_mode,
  // multiplier outputs
  output logic o_mult_on,
  output logic o_mult_clk,
  output logic o_mult_locked,
  // oscillator pin takeover
  output logic o_osc_pin_in_used,
  output logic o_osc_pin_out_used
);

  localparam logic [11:0] LOCK_LAST = 12'(`PLL_LOCK_CYCLES - 1);

  ctrl_state_t st;
  ctrl_state_t next_st;
  logic wr_hit;
  logic rd_hit;
  logic src_edge;
  logic gen_pulse;
  logic [2:0] burst;
  logic [2:0] period;
  logic [7:0] wd;

  // length of each group of fast pulses, two of which are kept
  function automatic logic [2:0] keep_period(input logic [2:0] scale);
    case (scale)
      `PLL_SCALE_2_3: keep_period = 3'h3;
      `PLL_SCALE_2_4: keep_period = 3'h4;
      `PLL_SCALE_2_5: keep_period = 3'h5;
      `PLL_SCALE_2_6: keep_period = 3'h6;
      `PLL_SCALE_2_7: keep_period = 3'h7;
      default: keep_period = `PLL_KEEP_ALL;
    endcase
  endfunction

  function automatic logic [7:0] reg_image(input ctrl_state_t s);
    reg_image = {s.en,
                 s.init_hold & ~s.en, // R2
                 s.fsm == ST_LOCKED, // R4
                 s.scale, s.src};
  endfunction

  assign wd = i_sfr_req.wdata;
  assign wr_hit = i_sfr_req.wr && (i_sfr_req.addr == `PLL_CTRL_ADDR);
  assign rd_hit = i_sfr_req.addr == `PLL_CTRL_ADDR;
  // only the second synchroniser stage feeds the edge detector
  assign src_edge = st.sync2[st.src[`PLL_SRC_SEL_EXT]] &
                    ~st.prev[st.src[`PLL_SRC_SEL_EXT]]; // R7
  assign burst = st.src[`PLL_SRC_SEL_X4] ? `PLL_BURST_X4 :
                 `PLL_BURST_X2; // R7
  assign period = (st.src == `PLL_SRC_INT_X2) ? `PLL_KEEP_ALL :
                  keep_period(st.scale); // R8

  always_comb begin
    next_st = st;
    next_st.sync1 = {i_ext_osc_clk, i_int_osc_clk};
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    case (st.fsm)
      ST_OFF: next_st.lock_cnt = '0;
      ST_IDLE: next_st.lock_cnt = '0;
      ST_LOCKING: begin
        if (st.lock_cnt == LOCK_LAST) begin
          next_st.fsm = ST_LOCKED; // R4
        end else begin
          next_st.lock_cnt = st.lock_cnt + 12'h001;
        end
      end
      ST_LOCKED: next_st.lock_cnt = '0;
      default: next_st.fsm = ST_OFF;
    endcase
    if (wr_hit) begin
      next_st.en = wd[`PLL_BIT_EN];
      next_st.init_hold = wd[`PLL_BIT_INIT];
      next_st.scale = wd[`PLL_SCALE_HI:`PLL_SCALE_LO];
      next_st.src = wd[`PLL_SRC_HI:`PLL_SRC_LO];
      if (!wd[`PLL_BIT_EN]) begin
        next_st.fsm = ST_OFF; // R1 R14
        next_st.lock_cnt = '0;
      end else if (st.en && wd[`PLL_BIT_INIT]) begin
        // re-initialising a locked loop drops ready until relock
        next_st.fsm = ST_LOCKING; // R3 R14
        next_st.lock_cnt = '0;
      end else if (!st.en) begin
        next_st.fsm = ST_IDLE; // R1
      end
    end
    // read data lags the address by one cycle; unmapped reads give zero
    next_st.rdata = rd_hit ? reg_image(st) : 8'h00;
    next_st.mult_clk = gen_pulse;
    next_st.pin_in = i_osc_mode[2:1] == `OSC_MODE_XTAL; // R9
    next_st.pin_out = i_osc_mode[2:1] != `OSC_MODE_OFF; // R9
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '0;
      st.fsm <= ST_OFF;
    end else begin
      st <= next_st;
    end
  end

  mult_pulse_gen u_gen (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_run(st.en), // R1
    .i_edge(src_edge),
    .i_burst(burst),
    .i_period(period),
    .o_pulse(gen_pulse)
  );

  assign o_sfr_rdata = st.rdata;
  assign o_mult_on = st.en;
  assign o_mult_clk = st.mult_clk;
  // one-hot state bit, so ready comes straight from a flop
  assign o_mult_locked = st.fsm[`PLL_FSM_LOCKED_BIT];
  assign o_osc_pin_in_used = st.pin_in;
  assign o_osc_pin_out_used = st.pin_out;

  // a slot decided before the write still drains through two flops
  chk_disable_stops: assert property (@(posedge i_sys_clk) // R1
    disable iff (!i_rst_b)
    wr_hit && !wd[`PLL_BIT_EN] |=> !o_mult_on && !o_mult_locked ##2
    !o_mult_clk) else $error("multiplier still on after disable");

  chk_init_reads_zero: assert property (@(posedge i_sys_clk) // R2
    disable iff (!i_rst_b)
    rd_hit && st.en |=> !o_sfr_rdata[`PLL_BIT_INIT])
    else $error("initialize bit read as one while enabled");

  chk_init_starts: assert property (@(posedge i_sys_clk) // R3
    disable iff (!i_rst_b)
    wr_hit && st.en && wd[`PLL_BIT_EN] && wd[`PLL_BIT_INIT]
    |=> st.fsm == ST_LOCKING && st.lock_cnt == 12'h000)
    else $error("initialize write did not start locking");

  chk_ready_read: assert property (@(posedge i_sys_clk) // R4
    disable iff (!i_rst_b)
    rd_hit |=> o_sfr_rdata[`PLL_BIT_RDY] == $past(o_mult_locked))
    else $error("ready bit does not follow lock");

  chk_lock_time: assert property (@(posedge i_sys_clk) // R4
    disable iff (!i_rst_b)
    $rose(o_mult_locked) |-> $past(st.lock_cnt) == LOCK_LAST)
    else $error("lock reached at wrong count");

  chk_ready_clears: assert property (@(posedge i_sys_clk) // R14
    disable iff (!i_rst_b)
    o_mult_locked && wr_hit && (!wd[`PLL_BIT_EN] || wd[`PLL_BIT_INIT])
    |=> !o_mult_locked) else $error("ready not cleared");

  chk_int_x2_bypass: assert property (@(posedge i_sys_clk) // R8
    disable iff (!i_rst_b)
    st.src == `PLL_SRC_INT_X2 |-> period == `PLL_KEEP_ALL &&
    burst == `PLL_BURST_X2) else $error("scale used on internal x2");

  chk_pin_use: assert property (@(posedge i_sys_clk) // R9
    disable iff (!i_rst_b)
    ##1 o_osc_pin_in_used |-> o_osc_pin_out_used &&
    $past(i_osc_mode[2:1]) == `OSC_MODE_XTAL)
    else $error("input pin taken outside crystal mode");

  cover_lock: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    $rose(o_mult_locked));
  cover_reinit: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    o_mult_locked && wr_hit && wd[`PLL_BIT_INIT] && wd[`PLL_BIT_EN]);
  cover_crystal: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    o_osc_pin_in_used && o_mult_clk);

endmodule // clock_multiplier_control

// ==== rtl/pll_defs.svh ====
// constants for the clock multiplier control block
`ifndef PLL_DEFS_SVH
`define PLL_DEFS_SVH

`define PLL_CTRL_ADDR 8'h97
`define PLL_CTRL_RESET 8'h00
`define PLL_BIT_EN 7
`define PLL_BIT_INIT 6
`define PLL_BIT_RDY 5
`define PLL_SCALE_HI 4
`define PLL_SCALE_LO 2
`define PLL_SRC_HI 1
`define PLL_SRC_LO 0
`define PLL_FSM_LOCKED_BIT 3

`define PLL_SRC_INT_X2 2'h0
`define PLL_SRC_SEL_EXT 0
`define PLL_SRC_SEL_X4 1

`define PLL_SCALE_1A 3'h0
`define PLL_SCALE_1B 3'h1
`define PLL_SCALE_2_3 3'h2
`define PLL_SCALE_2_4 3'h3
`define PLL_SCALE_2_5 3'h4
`define PLL_SCALE_2_6 3'h5
`define PLL_SCALE_2_7 3'h6
`define PLL_KEEP_ALL 3'h1
`define PLL_KEEP_N 3'h2

`define PLL_BURST_X2 3'h2
`define PLL_BURST_X4 3'h4

`define OSC_MODE_OFF 2'h0
`define OSC_MODE_XTAL 2'h3

`define SYS_PERIOD_NS 8
`define PLL_LOCK_TIME_NS 20000
`define PLL_LOCK_CYCLES \
  ((`PLL_LOCK_TIME_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS)
`define PLL_LOCK_CNT_W 12

`endif

// ==== rtl/pll_pkg.sv ====
// types for the clock multiplier control block
package pll_pkg;

  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_IDLE = 4'b0010,
    ST_LOCKING = 4'b0100,
    ST_LOCKED = 4'b1000
  } pll_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } sfr_req_t;

  typedef struct packed {
    pll_state_t fsm;
    logic [7:0] rdata;
    logic en;
    logic init_hold;
    logic [2:0] scale;
    logic [1:0] src;
    logic [11:0] lock_cnt;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
    logic mult_clk;
    logic pin_in;
    logic pin_out;
  } ctrl_state_t;

  typedef struct packed {
    logic [2:0] left;
    logic phase;
    logic [2:0] keep;
    logic pulse;
  } gen_state_t;

endpackage

// ==== rtl/mult_pulse_gen.sv ====
// fast pulse bursts per source edge, thinned by the scale ratio
`timescale 1ns/100ps
`include "pll_defs.svh"
module mult_pulse_gen import pll_pkg::*; (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // control
  input wire logic i_run,
  input wire logic i_edge,
  input wire logic [2:0] i_burst,
  input wire logic [2:0] i_period,
  // output
  output logic o_pulse
);

  gen_state_t st;
  gen_state_t next_st;
  logic [2:0] seen;

  // a slow source gives a burst, then silence until the next edge
  always_comb begin
    next_st = st;
    next_st.pulse = 1'b0;
    if (!i_run) begin
      next_st.left = 3'h0;
      next_st.phase = 1'b0;
      next_st.keep = 3'h0;
    end else if (i_edge) begin
      next_st.left = i_burst; // R13
      next_st.phase = 1'b0;
    end else if (!st.phase && st.left != 3'h0) begin
      // keep two of every period pulses: odd ratios are not 50% duty
      next_st.pulse = (i_period == `PLL_KEEP_ALL) ||
                      (st.keep < `PLL_KEEP_N); // R5 R6
      next_st.keep = (st.keep >= i_period - 3'h1) ? 3'h0 : st.keep + 3'h1;
      next_st.left = st.left - 3'h1;
      next_st.phase = 1'b1;
    end else begin
      next_st.phase = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_pulse = st.pulse;

  // pulses since the last source edge, for checking only
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      seen <= 3'h0;
    end else if (i_edge || !i_run) begin
      seen <= 3'h0;
    end else if (st.pulse && seen != 3'h7) begin
      seen <= seen + 3'h1;
    end
  end

  chk_burst_limit: assert property ( // R13
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    seen <= `PLL_BURST_X4) else $error("more than four pulses per edge");

  chk_scale_drop: assert property ( // R5
    @(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_run && !i_edge && !st.phase && st.left != 3'h0 &&
     i_period != `PLL_KEEP_ALL && st.keep >= `PLL_KEEP_N)
    |=> !o_pulse) else $error("scaled pulse not dropped");

  chk_burst_spacing: assert property (@(posedge i_sys_clk) // R13
    disable iff (!i_rst_b)
    o_pulse |=> !o_pulse) else $error("fast pulses not separated");

  cover_x4_burst: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    seen == `PLL_BURST_X4);

endmodule // mult_pulse_gen

// ==== verification/test_clock_multiplier_control.sv ====
// self-checking bench for the clock multiplier control block
`timescale 1ns/100ps
`include "pll_defs.svh"
module test_clock_multiplier_control import pll_pkg::*;;
  typedef struct packed {
    logic [2:0] sel;
    logic [15:0] val;
  } note_t;
  // slot count 4*105 divides evenly by every group length, 2*105 by all but 4
  localparam int EDGES = 105;
  // more than 5 us of 8 ns cycles between enable and initialize
  localparam int SETTLE = 626;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  sfr_req_t i_sfr_req = '0;
  logic i_int_osc_clk = 1'b0;
  logic i_ext_osc_clk = 1'b0;
  logic [2:0] i_osc_mode = 3'h0;
  logic [7:0] o_sfr_rdata;
  logic o_mult_on;
  logic o_mult_clk;
  logic o_mult_locked;
  logic o_osc_pin_in_used;
  logic o_osc_pin_out_used;
  logic [15:0] pulses = 16'h0000;
  note_t notes[$];
  event look;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;

  clock_multiplier_control dut (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_sfr_req(i_sfr_req),
    .o_sfr_rdata(o_sfr_rdata),
    .i_int_osc_clk(i_int_osc_clk),
    .i_ext_osc_clk(i_ext_osc_clk),
    .i_osc_mode(i_osc_mode),
    .o_mult_on(o_mult_on),
    .o_mult_clk(o_mult_clk),
    .o_mult_locked(o_mult_locked),
    .o_osc_pin_in_used(o_osc_pin_in_used),
    .o_osc_pin_out_used(o_osc_pin_out_used)
  );

  always #4 i_sys_clk = ~i_sys_clk;

  always @(posedge i_sys_clk) begin
    if (o_mult_clk === 1'b1) begin
      pulses <= pulses + 16'h0001;
    end
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // second process: compares the oldest note with what the outputs show
  always @(look) begin : watch
    note_t n;
    n = notes.pop_front();
    case (n.sel)
      3'h0: check("rdata", {8'h00, o_sfr_rdata}, n.val);
      3'h1: check("mult_on", {15'h0000, o_mult_on}, n.val);
      3'h2: check("locked", {15'h0000, o_mult_locked}, n.val);
      3'h3: check("pin_in", {15'h0000, o_osc_pin_in_used}, n.val);
      3'h4: check("pin_out", {15'h0000, o_osc_pin_out_used}, n.val);
      default: check("pulses", pulses, n.val);
    endcase
  end

  task automatic note(logic [2:0] sel, logic [15:0] val);
    notes.push_back('{sel: sel, val: val});
    -> look;
    #1;
  endtask

  task automatic wr(logic [7:0] d);
    @(posedge i_sys_clk) #1;
    i_sfr_req.addr = `PLL_CTRL_ADDR;
    i_sfr_req.wdata = d;
    i_sfr_req.wr = 1'b1;
    @(posedge i_sys_clk) #1;
    i_sfr_req.wr = 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge i_sys_clk) #1;
    i_sfr_req.addr = a;
    @(posedge i_sys_clk) #2;
    note(3'h0, {8'h00, exp});
  endtask

  // bring-up order: clear, configure, enable, settle, initialize, poll
  task automatic lock(logic [7:0] cfg);
    wr(8'h00);
    wr(cfg);
    wr(8'h80 | cfg);
    repeat (SETTLE) @(posedge i_sys_clk);
    wr(8'hC0 | cfg);
    note(3'h2, 16'h0000);
    repeat (`PLL_LOCK_CYCLES - 1) @(posedge i_sys_clk);
    #2;
    note(3'h2, 16'h0000);
    @(posedge i_sys_clk) #2;
    note(3'h2, 16'h0001);
  endtask

  task automatic run_src(logic [1:0] src, logic [2:0] sc, logic on);
    logic [15:0] c0;
    logic [15:0] exp;
    exp = (src[1] ? 16'h0004 : 16'h0002) * EDGES;
    if (src != 2'h0 && sc > 3'h1) begin
      exp = exp * 2 / (sc + 1);
    end
    if (on) begin
      // source pins stay quiet until the loop is initialized
      lock({3'h0, sc, src});
    end else begin
      wr({3'h0, sc, src});
      exp = 16'h0000;
    end
    c0 = pulses;
    repeat (EDGES) begin
      @(posedge i_sys_clk) #1;
      if (src[0]) i_ext_osc_clk = 1'b1; else i_int_osc_clk = 1'b1;
      repeat (6) @(posedge i_sys_clk);
      #1;
      i_ext_osc_clk = 1'b0;
      i_int_osc_clk = 1'b0;
      repeat (6 + $urandom % 4) @(posedge i_sys_clk);
    end
    repeat (20) @(posedge i_sys_clk);
    #2;
    notes.push_back('{sel: 3'h5, val: exp - 16'h0000 + c0});
    -> look;
    #1;
  endtask

  initial begin : main
    logic [7:0] a;
    repeat (8) @(posedge i_sys_clk);
    #1;
    i_rst_b = 1'b1;
    void'($urandom(48));
    rd(`PLL_CTRL_ADDR, 8'h00);
    a = $urandom % 256;
    if (a == `PLL_CTRL_ADDR) a = 8'h00;
    rd(a, 8'h00);
    wr(8'h20);
    rd(`PLL_CTRL_ADDR, 8'h00);
    wr(8'h5D);
    note(3'h1, 16'h0000);
    rd(`PLL_CTRL_ADDR, 8'h5D);
    wr(8'hC0);
    note(3'h1, 16'h0001);
    rd(`PLL_CTRL_ADDR, 8'h80);
    lock(8'h00);
    rd(`PLL_CTRL_ADDR, 8'hA0);
    wr(8'hC0);
    note(3'h2, 16'h0000);
    lock(8'h00);
    wr(8'h00);
    note(3'h1, 16'h0000);
    note(3'h2, 16'h0000);
    for (int m = 0; m < 8; m++) begin
      @(posedge i_sys_clk) #1;
      i_osc_mode = m[2:0];
      @(posedge i_sys_clk) #2;
      note(3'h3, {15'h0000, m[2:1] == 2'h3});
      note(3'h4, {15'h0000, m[2:1] != 2'h0});
    end
    // pulse count check folds the start count into the expectation
    for (int s = 0; s < 7; s++) begin
      run_src(2'h2, s[2:0], 1'b1);
    end
    run_src(2'h3, 3'h4, 1'b1);
    run_src(2'h1, 3'h6, 1'b1);
    run_src(2'h0, 3'h3, 1'b1);
    run_src(2'h2, 3'h0, 1'b0);
    give_verdict();
  end
endmodule // test_clock_multiplier_control
